// ### hdl/dcs_top.v
// dcs_top.v: operation mode and command source selector of a drive
// assumes: single 250 MHz clock, pins are asynchronous, a register
// master on the same clock using one-cycle strobes
//
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/10ps
`include "dcs_defs.vh"

module dcs_top (
  // clock and reset
  input wire REF_CLK,
  input wire RST,
  // register port
  input wire [3:0] REG_ADDR,
  input wire [7:0] REG_WDATA,
  input wire REG_WR,
  input wire REG_RD,
  output reg [7:0] REG_RDATA,
  // terminal pins (asynchronous)
  input wire FORWARD_START_INPUT,
  input wire REVERSE_START_INPUT,
  input wire CURRENT_INPUT_SELECT,
  input wire PANEL_LOCK_INPUT,
  input wire MULTI_SPEED_INPUT,
  input wire JOG_INPUT,
  // panel keys (asynchronous)
  input wire PANEL_MODE_KEY,
  input wire PANEL_RUN_KEY,
  input wire PANEL_STOP_KEY,
  // network mode change instruction, same clock
  input wire NET_MODE_REQ,
  input wire [1:0] NET_MODE_CODE,
  input wire NET_START,
  // motor state from the drive, same clock
  input wire MOTOR_RUNNING,
  // selected sources
  output reg [2:0] FREQ_SOURCE,
  output reg [1:0] START_SOURCE,
  output reg START_CMD,
  output reg OUTPUT_STOP,
  output reg PARAM_WRITE_OPEN,
  output reg [2:0] MODE_ONEHOT
);

  // ----------------------------------------------------------------
  // operation mode states, one-hot
  // ----------------------------------------------------------------
  localparam [2:0] ST_TERM = 3'b001; // terminal_control_mode
  localparam [2:0] ST_PANEL = 3'b010; // panel_unit_mode
  localparam [2:0] ST_NET = 3'b100; // network operation

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  wire [8:0] pins_s; // synchronised pin levels
  dcs_sync #(.W(9)) u_sync (
    .clk(REF_CLK),
    .rst(RST),
    .d({PANEL_STOP_KEY, PANEL_RUN_KEY, PANEL_MODE_KEY, JOG_INPUT,
        MULTI_SPEED_INPUT, PANEL_LOCK_INPUT, CURRENT_INPUT_SELECT,
        REVERSE_START_INPUT, FORWARD_START_INPUT}),
    .q(pins_s)
  );
  wire fwd_s = pins_s[0];
  wire rev_s = pins_s[1];
  wire cursel_s = pins_s[2];
  wire lock_s = pins_s[3];
  wire mspd_s = pins_s[4];
  wire jog_s = pins_s[5];
  wire modekey_s = pins_s[6];
  wire runkey_s = pins_s[7];
  wire stopkey_s = pins_s[8];

  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  reg [3:0] setting_r; // command_source_setting
  reg [3:0] ctrl_r; // software mode request and stop enable
  reg [2:0] mode_r; // current operation mode
  reg [2:0] mode_nxt;
  reg modekey_d_r; // previous mode key level for edge detect
  reg pwr_on_r; // first cycle after reset applies power-on mode

  wire modekey_rise = modekey_s & ~modekey_d_r;
  wire sw_req = REG_WR && (REG_ADDR == `DCS_OFS_CTRL) &&
                (REG_WDATA[2:0] != 3'h0);

  // supported setting values; 5 and above 7 are refused
  wire set_valid = (REG_WDATA[7:4] == 4'h0) &&
                   (REG_WDATA[3:0] != 4'h5) && (REG_WDATA[3:0] <= 4'h7);

  // ----------------------------------------------------------------
  // power-on mode for a given setting
  // ----------------------------------------------------------------
  function [2:0] boot_mode;
    input [3:0] s;
    begin
      if (s == `DCS_SET_PANEL) begin
        boot_mode = ST_PANEL;
      end else begin
        boot_mode = ST_TERM;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // setting register: written only while stopped, bad values refused
  // ----------------------------------------------------------------
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      setting_r <= `DCS_SET_RESET;
      ctrl_r <= `DCS_CTRL_RESET;
    end else begin
      if (REG_WR && REG_ADDR == `DCS_OFS_SETTING && !MOTOR_RUNNING && set_valid) begin
        setting_r <= REG_WDATA[3:0];
      end
      if (REG_WR && REG_ADDR == `DCS_OFS_CTRL) begin
        ctrl_r <= REG_WDATA[3:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // mode state machine
  // ----------------------------------------------------------------
  always @* begin
    mode_nxt = mode_r;
    case (setting_r)
      `DCS_SET_SWITCH: begin
        // panel key flips terminal and panel, only while stopped
        if (modekey_rise && !MOTOR_RUNNING) begin
          mode_nxt = (mode_r == ST_TERM) ? ST_PANEL : ST_TERM;
        end
      end
      `DCS_SET_TERM: begin
        mode_nxt = ST_TERM;
      end
      `DCS_SET_PANEL: begin
        mode_nxt = ST_PANEL;
      end
      `DCS_SET_COMB1, `DCS_SET_COMB2: begin
        // combined modes sit in terminal state, no switching
        mode_nxt = ST_TERM;
      end
      `DCS_SET_FREE: begin
        // any source may switch, running or not
        if (NET_MODE_REQ) begin
          mode_nxt = NET_MODE_CODE == 2'h1 ? ST_PANEL :
                     NET_MODE_CODE == 2'h2 ? ST_NET : ST_TERM;
        end else if (sw_req) begin
          mode_nxt = REG_WDATA[`DCS_CTRL_REQ_NET] ? ST_NET :
                     REG_WDATA[`DCS_CTRL_REQ_PANEL] ? ST_PANEL : ST_TERM;
        end else if (modekey_rise) begin
          mode_nxt = (mode_r == ST_PANEL) ? ST_TERM : ST_PANEL;
        end
      end
      `DCS_SET_ILOCK: begin
        if (!lock_s) begin
          mode_nxt = ST_TERM;
        end else if (NET_MODE_REQ) begin
          mode_nxt = NET_MODE_CODE == 2'h1 ? ST_PANEL :
                     NET_MODE_CODE == 2'h2 ? ST_NET : ST_TERM;
        end else if (sw_req) begin
          mode_nxt = REG_WDATA[`DCS_CTRL_REQ_NET] ? ST_NET :
                     REG_WDATA[`DCS_CTRL_REQ_PANEL] ? ST_PANEL : ST_TERM;
        end else if (modekey_rise) begin
          mode_nxt = (mode_r == ST_PANEL) ? ST_TERM : ST_PANEL;
        end
      end
      default: begin
        mode_nxt = mode_r;
      end
    endcase
  end

  // state register; power-on mode applied once after reset release
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      mode_r <= ST_TERM;
      modekey_d_r <= 1'b0;
      pwr_on_r <= 1'b1;
    end else begin
      modekey_d_r <= modekey_s;
      pwr_on_r <= 1'b0;
      if (pwr_on_r) begin
        mode_r <= boot_mode(setting_r);
      end else begin
        mode_r <= mode_nxt;
      end
    end
  end

  // ----------------------------------------------------------------
  // source selection and start command
  // ----------------------------------------------------------------
  reg [2:0] fsrc_nxt;
  reg [1:0] ssrc_nxt;
  reg start_nxt;
  wire pin_start = fwd_s | rev_s;

  // frequency from terminals: multispeed, jog, current select, analog
  function [2:0] term_freq;
    input m;
    input j;
    input c;
    begin
      if (m) begin
        term_freq = `DCS_FSRC_MSPD;
      end else if (j) begin
        term_freq = `DCS_FSRC_JOG;
      end else if (c) begin
        term_freq = `DCS_FSRC_AN4;
      end else begin
        term_freq = `DCS_FSRC_AN2;
      end
    end
  endfunction

  always @* begin
    fsrc_nxt = `DCS_FSRC_PANEL;
    ssrc_nxt = `DCS_SSRC_TERM;
    start_nxt = 1'b0;
    if (setting_r == `DCS_SET_COMB1) begin
      // panel frequency unless multispeed or current select wins
      fsrc_nxt = mspd_s ? `DCS_FSRC_MSPD :
                 cursel_s ? `DCS_FSRC_AN4 : `DCS_FSRC_PANEL;
      ssrc_nxt = `DCS_SSRC_TERM;
      start_nxt = pin_start;
    end else if (setting_r == `DCS_SET_COMB2) begin
      fsrc_nxt = term_freq(mspd_s, jog_s, cursel_s);
      ssrc_nxt = `DCS_SSRC_PANEL;
      start_nxt = runkey_s;
    end else begin
      case (mode_r)
        ST_TERM: begin
          fsrc_nxt = term_freq(mspd_s, jog_s, cursel_s);
          ssrc_nxt = `DCS_SSRC_TERM;
          start_nxt = pin_start;
        end
        ST_PANEL: begin
          fsrc_nxt = `DCS_FSRC_PANEL;
          ssrc_nxt = `DCS_SSRC_PANEL;
          start_nxt = runkey_s;
        end
        ST_NET: begin
          fsrc_nxt = `DCS_FSRC_NET;
          ssrc_nxt = `DCS_SSRC_NET;
          start_nxt = NET_START;
        end
        default: begin
          fsrc_nxt = `DCS_FSRC_PANEL;
        end
      endcase
    end
    // panel stop overrides any source when enabled
    if (stopkey_s && ctrl_r[`DCS_CTRL_PSTOP_EN]) begin
      start_nxt = 1'b0;
    end
  end

  // interlock on during terminal operation stops the output
  wire stop_nxt = (setting_r == `DCS_SET_ILOCK) && lock_s && (mode_r == ST_TERM);

  // terminal mode closes general parameter writes, except in the combined settings
  wire wr_open_nxt = !(mode_r == ST_TERM) || (setting_r == `DCS_SET_COMB1) ||
                     (setting_r == `DCS_SET_COMB2);

  // ----------------------------------------------------------------
  // registered outputs and read port
  // ----------------------------------------------------------------
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      FREQ_SOURCE <= `DCS_FSRC_AN2;
      START_SOURCE <= `DCS_SSRC_TERM;
      START_CMD <= 1'b0;
      OUTPUT_STOP <= 1'b0;
      PARAM_WRITE_OPEN <= 1'b0;
      MODE_ONEHOT <= ST_TERM;
      REG_RDATA <= 8'h00;
    end else begin
      FREQ_SOURCE <= fsrc_nxt;
      START_SOURCE <= ssrc_nxt;
      START_CMD <= start_nxt & ~stop_nxt;
      OUTPUT_STOP <= stop_nxt;
      PARAM_WRITE_OPEN <= wr_open_nxt;
      MODE_ONEHOT <= mode_r;
      REG_RDATA <= 8'h00;
      if (REG_RD) begin
        case (REG_ADDR)
          `DCS_OFS_SETTING: REG_RDATA <= {4'h0, setting_r};
          `DCS_OFS_CTRL: REG_RDATA <= {4'h0, ctrl_r};
          `DCS_OFS_STATUS: REG_RDATA <= {MOTOR_RUNNING, lock_s, 1'b0, mode_r, ssrc_nxt};
          `DCS_OFS_WRGATE: REG_RDATA <= {7'h00, wr_open_nxt};
          default: REG_RDATA <= 8'h00;
        endcase
      end
    end
  end

endmodule

// ### hdl/dcs_defs.vh
// dcs_defs.vh: constants for the drive command source selector
// assumes: included by the design files by bare name, definitions only
`ifndef DCS_DEFS_VH
`define DCS_DEFS_VH

// ----------------------------------------------------------------
// register offsets (word addresses on the plain register port)
// ----------------------------------------------------------------
`define DCS_OFS_SETTING 4'h0
`define DCS_OFS_CTRL 4'h1
`define DCS_OFS_STATUS 4'h2
`define DCS_OFS_WRGATE 4'h3

// ----------------------------------------------------------------
// command source setting values
// ----------------------------------------------------------------
`define DCS_SET_SWITCH 4'h0
`define DCS_SET_PANEL 4'h1
`define DCS_SET_TERM 4'h2
`define DCS_SET_COMB1 4'h3
`define DCS_SET_COMB2 4'h4
`define DCS_SET_FREE 4'h6
`define DCS_SET_ILOCK 4'h7
`define DCS_SET_RESET 4'h0

// ----------------------------------------------------------------
// control register bit positions
// ----------------------------------------------------------------
`define DCS_CTRL_REQ_PANEL 0
`define DCS_CTRL_REQ_TERM 1
`define DCS_CTRL_REQ_NET 2
`define DCS_CTRL_PSTOP_EN 3
`define DCS_CTRL_RESET 4'h8

// ----------------------------------------------------------------
// frequency source codes
// ----------------------------------------------------------------
`define DCS_FSRC_PANEL 3'h0
`define DCS_FSRC_AN2 3'h1
`define DCS_FSRC_AN4 3'h2
`define DCS_FSRC_MSPD 3'h3
`define DCS_FSRC_JOG 3'h4
`define DCS_FSRC_NET 3'h5

// ----------------------------------------------------------------
// start source codes
// ----------------------------------------------------------------
`define DCS_SSRC_TERM 2'h0
`define DCS_SSRC_PANEL 2'h1
`define DCS_SSRC_NET 2'h2

`endif

// ### hdl/dcs_sync.v
// dcs_sync.v: two-flop synchroniser for a bank of pin levels
// assumes: inputs come from pins outside the ref_clk domain
`timescale 1ns/10ps

module dcs_sync #(
  parameter W = 8
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // pin levels in, synchronised levels out
  input wire [W-1:0] d,
  output reg [W-1:0] q
);

  // ----------------------------------------------------------------
  // two stages; first stage feeds only the second
  // ----------------------------------------------------------------
  reg [W-1:0] meta_r; // first stage, read by q only

  // both stages clear to zero so no pin looks active at reset
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

// ### tb/dcs_assertions.sv
// dcs_assertions.sv: port checks for the command source selector
// assumes: bound into dcs_top, one clock, async active high reset
`timescale 1ns/10ps

module dcs_chk (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // register port
  input wire logic [3:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  // pins and motor state
  input wire logic MOTOR_RUNNING,
  input wire logic PANEL_STOP_KEY,
  input wire logic PANEL_LOCK_INPUT,
  input wire logic MULTI_SPEED_INPUT,
  // selected sources
  input wire logic [2:0] FREQ_SOURCE,
  input wire logic [1:0] START_SOURCE,
  input wire logic START_CMD,
  input wire logic OUTPUT_STOP,
  input wire logic PARAM_WRITE_OPEN,
  input wire logic [2:0] MODE_ONEHOT
);
  logic [3:0] set_r; // accepted setting
  logic pstop_r; // stop key enable
  logic ok_set; // write that the setting accepts
  assign ok_set = REG_ADDR == 4'h0 && !MOTOR_RUNNING && REG_WDATA < 8'h08 && REG_WDATA != 8'h05;
  // shadows follow accepted writes only
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      set_r <= 4'h0;
      pstop_r <= 1'b1;
    end else if (REG_WR) begin
      if (ok_set) begin
        set_r <= REG_WDATA[3:0];
      end
      if (REG_ADDR == 4'h1) begin
        pstop_r <= REG_WDATA[3];
      end
    end
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // repeats cover synchroniser and output register delay
  sequence stop_held;
    (pstop_r && PANEL_STOP_KEY) [*4];
  endsequence
  chk_stop_halts: assert property (stop_held |-> !START_CMD)
    else $error("start during panel stop");
  chk_mode_onehot: assert property ($onehot(MODE_ONEHOT))
    else $error("mode not one-hot");
  chk_net_mode: assert property (START_SOURCE == 2'h2 [*3] |-> MODE_ONEHOT == 3'b100)
    else $error("net start outside net mode");
  chk_stop_no_start: assert property (OUTPUT_STOP |-> !START_CMD)
    else $error("start while output stopped");
  chk_lock_forces: assert property
    ((set_r == 4'h7 && !PANEL_LOCK_INPUT) [*6] |-> MODE_ONEHOT == 3'b001)
    else $error("lock off not terminal");
  chk_panel_fixed: assert property ((set_r == 4'h1) [*5] |->
    MODE_ONEHOT == 3'b010 && START_SOURCE == 2'h1 && PARAM_WRITE_OPEN)
    else $error("setting 1 not panel");
  chk_term_fixed: assert property ((set_r == 4'h2) [*5] |->
    MODE_ONEHOT == 3'b001 && !PARAM_WRITE_OPEN)
    else $error("setting 2 not terminal");
  chk_comb_mspd: assert property ((set_r == 4'h3 && MULTI_SPEED_INPUT) [*5] |->
    START_SOURCE == 2'h0 && FREQ_SOURCE == 3'h3)
    else $error("multispeed not preferred");
  chk_comb_panel: assert property ((set_r == 4'h4) [*5] |->
    START_SOURCE == 2'h1 && MODE_ONEHOT == 3'b001)
    else $error("setting 4 start not panel");
endmodule

bind dcs_top dcs_chk u_chk (.REF_CLK, .RST, .REG_ADDR, .REG_WDATA, .REG_WR, .MOTOR_RUNNING,
  .PANEL_STOP_KEY, .PANEL_LOCK_INPUT, .MULTI_SPEED_INPUT, .FREQ_SOURCE, .START_SOURCE,
  .START_CMD, .OUTPUT_STOP, .PARAM_WRITE_OPEN, .MODE_ONEHOT);

// ### tb/dcs_far_side.sv
// dcs_far_side.sv: terminals, panel keys and network link
// assumes: pins are levels, changed just after a clock edge
`timescale 1ns/10ps

module dcs_far_side (
  // clock
  input wire logic clk,
  // 0 fwd 1 rev 2 cur 3 lock 4 mspd 5 jog 6 mode key 7 run 8 stop
  output logic [8:0] pins,
  // network instruction
  output logic net_req,
  output logic [1:0] net_code,
  output logic net_start
);
  // everything idle at time zero
  initial begin
    pins = 9'h000;
    net_req = 1'b0;
    net_code = 2'h0;
    net_start = 1'b0;
  end
  task automatic set_pin(input int i, input logic v);
    @(posedge clk);
    pins[i] <= v;
  endtask
  // key press long enough for the synchroniser
  task automatic tap(input int i);
    set_pin(i, 1'b1);
    repeat (5) @(posedge clk);
    pins[i] <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  // network start level, same clock as the design
  task automatic net_run(input logic v);
    @(posedge clk);
    net_start <= v;
  endtask
  // one-cycle mode change instruction
  task automatic net_send(input logic [1:0] c);
    @(posedge clk);
    net_req <= 1'b1;
    net_code <= c;
    @(posedge clk);
    net_req <= 1'b0;
  endtask
endmodule

// ### tb/drive_command_source_selector_test.sv
// drive_command_source_selector_test.sv: directed bench for dcs_top
// assumes: dcs_far_side drives pins, bench drives registers
`timescale 1ns/10ps

module drive_command_source_selector_test;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic running = 1'b0;
  wire [7:0] rdata;
  wire [8:0] p;
  wire nreq, nstart, scmd, ostop, pwo;
  wire [1:0] ncode, ssrc;
  wire [2:0] fsrc, mode;
  int fails = 0;
  int comparisons = 0;
  always #2 ref_clk = ~ref_clk;
  dcs_far_side far (.clk(ref_clk), .pins(p), .net_req(nreq), .net_code(ncode),
    .net_start(nstart));
  dcs_top DUT (.REF_CLK(ref_clk), .RST(rst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(rdata), .FORWARD_START_INPUT(p[0]),
    .REVERSE_START_INPUT(p[1]), .CURRENT_INPUT_SELECT(p[2]), .PANEL_LOCK_INPUT(p[3]),
    .MULTI_SPEED_INPUT(p[4]), .JOG_INPUT(p[5]), .PANEL_MODE_KEY(p[6]), .PANEL_RUN_KEY(p[7]),
    .PANEL_STOP_KEY(p[8]), .NET_MODE_REQ(nreq), .NET_MODE_CODE(ncode), .NET_START(nstart),
    .MOTOR_RUNNING(running), .FREQ_SOURCE(fsrc), .START_SOURCE(ssrc), .START_CMD(scmd),
    .OUTPUT_STOP(ostop), .PARAM_WRITE_OPEN(pwo), .MODE_ONEHOT(mode));
  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // motor state changes just after a rising edge
  task automatic set_run(input logic v);
    @(posedge ref_clk);
    running <= v;
  endtask
  // data stands only in the cycle after the read edge
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 cmp("rdata", e, rdata);
  endtask
  // let pins cross the synchroniser, then compare the sources
  task automatic sel(input logic [2:0] m, input logic [1:0] s, input logic [2:0] f,
    input logic w);
    repeat (8) @(posedge ref_clk);
    #1 cmp("mode", {5'h00, m}, {5'h00, mode});
    cmp("start source", {6'h00, s}, {6'h00, ssrc});
    cmp("freq source", {5'h00, f}, {5'h00, fsrc});
    cmp("write open", {7'h00, w}, {7'h00, pwo});
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // hang guard, far above the few hundred cycles used
  initial begin
    #100000;
    fails++;
    report_and_stop;
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    sel(3'b001, 2'h0, 3'h1, 1'b0);
    rd(4'h0, 8'h00);
    far.set_pin(0, 1'b1);
    sel(3'b001, 2'h0, 3'h1, 1'b0);
    cmp("start", 8'h01, {7'h00, scmd});
    far.set_pin(5, 1'b1);
    sel(3'b001, 2'h0, 3'h4, 1'b0);
    far.set_pin(2, 1'b1);
    far.set_pin(5, 1'b0);
    sel(3'b001, 2'h0, 3'h2, 1'b0);
    far.set_pin(0, 1'b0);
    far.set_pin(2, 1'b0);
    far.set_pin(1, 1'b1);
    sel(3'b001, 2'h0, 3'h1, 1'b0);
    cmp("start", 8'h01, {7'h00, scmd});
    far.set_pin(1, 1'b0);
    far.tap(6);
    sel(3'b010, 2'h1, 3'h0, 1'b1);
    set_run(1'b1);
    far.tap(6);
    sel(3'b010, 2'h1, 3'h0, 1'b1);
    wr(4'h0, 8'h02);
    rd(4'h0, 8'h00);
    set_run(1'b0);
    far.tap(6);
    sel(3'b001, 2'h0, 3'h1, 1'b0);
    wr(4'h0, 8'h05);
    rd(4'h0, 8'h00);
    wr(4'h0, 8'h12);
    rd(4'h0, 8'h00);
    wr(4'h0, 8'h02);
    rd(4'h0, 8'h02);
    far.tap(6);
    sel(3'b001, 2'h0, 3'h1, 1'b0);
    wr(4'h0, 8'h01);
    far.net_send(2'h2);
    sel(3'b010, 2'h1, 3'h0, 1'b1);
    far.set_pin(7, 1'b1);
    sel(3'b010, 2'h1, 3'h0, 1'b1);
    cmp("start", 8'h01, {7'h00, scmd});
    far.set_pin(8, 1'b1);
    sel(3'b010, 2'h1, 3'h0, 1'b1);
    cmp("start", 8'h00, {7'h00, scmd});
    far.set_pin(7, 1'b0);
    far.set_pin(8, 1'b0);
    wr(4'h0, 8'h03);
    sel(3'b001, 2'h0, 3'h0, 1'b1);
    far.set_pin(4, 1'b1);
    far.set_pin(2, 1'b1);
    sel(3'b001, 2'h0, 3'h3, 1'b1);
    far.set_pin(4, 1'b0);
    sel(3'b001, 2'h0, 3'h2, 1'b1);
    far.set_pin(2, 1'b0);
    wr(4'h0, 8'h04);
    sel(3'b001, 2'h1, 3'h1, 1'b1);
    far.set_pin(5, 1'b1);
    sel(3'b001, 2'h1, 3'h4, 1'b1);
    far.set_pin(5, 1'b0);
    wr(4'h0, 8'h06);
    set_run(1'b1);
    far.net_send(2'h2);
    sel(3'b100, 2'h2, 3'h5, 1'b1);
    far.net_run(1'b1);
    sel(3'b100, 2'h2, 3'h5, 1'b1);
    cmp("start", 8'h01, {7'h00, scmd});
    far.net_run(1'b0);
    wr(4'h1, 8'h09);
    sel(3'b010, 2'h1, 3'h0, 1'b1);
    far.net_send(2'h0);
    sel(3'b001, 2'h0, 3'h1, 1'b0);
    wr(4'h1, 8'h0c);
    sel(3'b100, 2'h2, 3'h5, 1'b1);
    far.net_send(2'h1);
    sel(3'b010, 2'h1, 3'h0, 1'b1);
    set_run(1'b0);
    wr(4'h0, 8'h07);
    sel(3'b001, 2'h0, 3'h1, 1'b0);
    wr(4'h1, 8'h09);
    sel(3'b001, 2'h0, 3'h1, 1'b0);
    far.set_pin(0, 1'b1);
    far.set_pin(3, 1'b1);
    sel(3'b001, 2'h0, 3'h1, 1'b0);
    cmp("stop", 8'h01, {7'h00, ostop});
    cmp("start", 8'h00, {7'h00, scmd});
    wr(4'h1, 8'h09);
    sel(3'b010, 2'h1, 3'h0, 1'b1);
    far.set_pin(3, 1'b0);
    sel(3'b001, 2'h0, 3'h1, 1'b0);
    cmp("start", 8'h01, {7'h00, scmd});
    far.set_pin(0, 1'b0);
    wr(4'h3, 8'h01);
    rd(4'h3, 8'h00);
    rd(4'h2, 8'h04);
    rd(4'h1, 8'h09);
    rd(4'hf, 8'h00);
    report_and_stop;
  end
endmodule
